// File: bench/gpio_pin_model.sv
// package pins of ports C and D: each wire follows the chip where enabled, else the board
module gpio_pin_model (
    input  wire logic [5:0] pcOut,
    input  wire logic [5:0] pcOe,
    input  wire logic [5:0] pcExt,
    input  wire logic [7:0] pdOut,
    input  wire logic [7:0] pdOe,
    input  wire logic [7:0] pdExt,
    output logic      [5:0] pcIn,
    output logic      [7:0] pdIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // board always drives a level, so a floating pin never reads as unknown
    always_comb begin
        pcIn = (pcOe & pcOut) | (~pcOe & pcExt);
        pdIn = (pdOe & pdOut) | (~pdOe & pdExt);
    end
endmodule

// File: bench/gpio_ports_c_d_altfunc_tb_top.sv
// self-checking bench for the port C / port D block
`include "gpio_cd_params.svh"

module gpio_ports_c_d_altfunc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] PCD = {`GPIO_PC_DATA_IDX, 2'b00};
    localparam logic [7:0] PDD = {`GPIO_PD_DATA_IDX, 2'b00};
    localparam logic [7:0] PCR = {`GPIO_PC_DIR_IDX, 2'b00};
    localparam logic [7:0] PDR = {`GPIO_PD_DIR_IDX, 2'b00};

    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, timer_a_external_clock, timer_b_external_clock;
    logic [7:0]  paddr, pdIn, pdOut, pdOe, pdExt;
    logic [31:0] pwdata, prdata;
    logic [5:0]  pcIn, pcOut, pcOe, pcExt;
    logic [4:0]  adcSel;
    logic [2:0]  taSel, tbSel;
    int          error_cnt, num_checks;

    gpio_ports_cd dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pcIn(pcIn), .pcOut(pcOut), .pcOe(pcOe), .pdIn(pdIn),
        .pdOut(pdOut), .pdOe(pdOe), .adcChannelSelect(adcSel),
        .timerAPrescaleSelect(taSel), .timerBPrescaleSelect(tbSel),
        .timerAExternalClock(timer_a_external_clock), .timerBExternalClock(timer_b_external_clock));

    gpio_pin_model pins (.pcOut(pcOut), .pcOe(pcOe), .pcExt(pcExt), .pdOut(pdOut),
        .pdOe(pdOe), .pdExt(pdExt), .pcIn(pcIn), .pdIn(pdIn));

    always #5 sys_clk = ~sys_clk;

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // pready read just after the rising edge is the value that edge sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic er);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            error_cnt++;
            give_verdict();
        end
        r = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, x);
    endtask

    // pin levels pass three synchroniser stages before they are readable
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic t_reset;
        rdc(PCR, 8'h00);
        rdc(PDR, 8'h00);
        chk({2'h0, pcOe}, 8'h00);
        chk(pdOe, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_portc;
        pcExt <= 6'h15;
        wr(PCD, 8'h2A);
        wr(PCR, 8'h0F);
        idle(8);
        chk({2'h0, pcOe}, 8'h0F);
        chk({2'h0, pcOut & pcOe}, 8'h0A);
        rdc(PCD, 8'h1A);
        wr(PCD, 8'h05);
        rdc(PCD, 8'h15);
        wr(PCR, 8'h3F);
        rdc(PCD, 8'h05);
        $display("test port c done");
    endtask

    task automatic t_clkout;
        wr(PCR, 8'h80);
        pcExt <= 6'h3F;
        idle(8);
        rdc(PCR, 8'h80);
        chk({2'h0, pcOe}, 8'h04);
        rdc(PCD, 8'h3B);
        @(posedge sys_clk);
        #1 chk({7'h00, pcOut[2]}, 8'h01);
        @(negedge sys_clk);
        #1 chk({7'h00, pcOut[2]}, 8'h00);
        wr(PCD, 8'h00);
        rdc(PCD, 8'h3B);
        wr(PCR, 8'h00);
        idle(1);
        chk({2'h0, pcOe}, 8'h00);
        $display("test clock out done");
    endtask

    task automatic t_portd;
        pdExt <= 8'h3C;
        wr(PDD, 8'hA5);
        wr(PDR, 8'hF0);
        idle(8);
        chk(pdOe, 8'hF0);
        chk(pdOut, 8'hA5);
        rdc(PDD, 8'hAC);
        $display("test port d done");
    endtask

    task automatic t_adc;
        logic [7:0] m;
        pdExt <= 8'hFF;
        wr(PDD, 8'hFF);
        for (int k = 0; k < `GPIO_PD_ADC_PINS; k++) begin
            m = ~(8'h01 << k);
            adcSel <= 5'(8 + k);
            wr(PDR, 8'h00);
            idle(8);
            rdc(PDD, m);
            wr(PDR, 8'hFF);
            idle(1);
            chk(pdOe, m);
            rdc(PDD, 8'hFF);
        end
        adcSel <= 5'h00;
        $display("test adc done");
    endtask

    task automatic t_timer;
        wr(PDR, 8'hFF);
        taSel <= `GPIO_PS_EXT_CLK;
        tbSel <= `GPIO_PS_EXT_CLK;
        pdExt <= 8'h50;
        idle(8);
        chk(pdOe, 8'hAF);
        chk({6'h00, timer_a_external_clock, timer_b_external_clock}, 8'h03);
        pdExt <= 8'h00;
        idle(8);
        chk({6'h00, timer_a_external_clock, timer_b_external_clock}, 8'h00);
        wr(PDR, 8'h00);
        pdExt <= 8'hFF;
        idle(8);
        rdc(PDD, 8'hAF);
        taSel <= 3'h3;
        tbSel <= 3'h6;
        pdExt <= 8'h50;
        idle(8);
        chk({6'h00, timer_a_external_clock, timer_b_external_clock}, 8'h00);
        rdc(PDD, 8'h50);
        $display("test timer clock done");
    endtask

    task automatic t_err;
        logic [7:0] r;
        logic e;
        apb(1'b0, 8'h10, 8'h00, r, e);
        chk({7'h00, e}, 8'h01);
        chk(r, 8'h00);
        apb(1'b1, 8'h19, 8'hFF, r, e);
        chk({7'h00, e}, 8'h01);
        rdc(PCR, 8'h00);
        $display("test unmapped done");
    endtask

    initial begin
        sys_clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h00000000; pcExt = 6'h00; pdExt = 8'h00;
        adcSel = 5'h00; taSel = 3'h0; tbSel = 3'h0; error_cnt = 0; num_checks = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_portc();
        t_clkout();
        t_portd();
        t_adc();
        t_timer();
        t_err();
        give_verdict();
    end
endmodule

// File: rtl/gpio_cd_params.svh
// constants for the port C / port D block: offsets, field positions, reset values
`ifndef GPIO_CD_PARAMS_SVH
`define GPIO_CD_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define GPIO_PC_DATA_IDX    6'h02
`define GPIO_PD_DATA_IDX    6'h03
`define GPIO_PC_DIR_IDX     6'h06
`define GPIO_PD_DIR_IDX     6'h07

`define GPIO_PC_WIDTH       6
`define GPIO_PD_WIDTH       8
`define GPIO_PC_CLK_PIN     2
`define GPIO_PC_CLKEN_BIT   7
`define GPIO_PD_ADC_PINS    7
`define GPIO_PD_TIMER_UNIT_A_PIN    6
`define GPIO_PD_TIMER_UNIT_B_PIN    4

// first adc channel that lands on port D pin 0
`define GPIO_ADC_PD_FIRST   5'h08
// prescaler code that selects the external clock pin
`define GPIO_PS_EXT_CLK     3'h7

`define GPIO_DIR_RESET      8'h00
`define GPIO_CLKEN_RESET    1'b0
`define GPIO_PIN_RESET      8'h00

`endif

// File: rtl/gpio_cd_pkg.sv
// types for the port C / port D block
package gpio_cd_pkg;

    typedef enum logic [0:0] {
        PHASE_WAIT  = 1'b0,
        PHASE_READY = 1'b1
    } bus_phase_e;

    typedef struct packed {
        logic [7:0] pcLatch;
        logic [5:0] pcDir;
        logic       clkOutEn;
        logic [7:0] pdLatch;
        logic [7:0] pdDir;
        logic [5:0] pcSync1;
        logic [5:0] pcSync2;
        logic [5:0] pcSync3;
        logic [5:0] pcPin;
        logic [7:0] pdSync1;
        logic [7:0] pdSync2;
        logic [7:0] pdSync3;
        logic [7:0] pdPin;
        logic [5:0] pcOutQ;
        logic [5:0] pcOe;
        logic [7:0] pdOut;
        logic [7:0] pdOe;
        logic       timerAClk;
        logic       timerBClk;
        bus_phase_e phase;
        logic [31:0] prdata;
        logic       pslverr;
    } gpio_state_s;

endpackage

// File: rtl/gpio_ports_cd.sv
// port C / port D general-purpose i/o with clock-out, adc and timer-clock sharing
//
// Functional notes
// - six port C data latches, direction per bit; reset keeps latch contents.
// - clock-output enable drives system clock on port C pin 2, overriding direction.
// - clock-output enable is software read/write and cleared by reset.
// - port C direction 1 drives the pin, 0 floats it; reset clears all.
// - port C data read gives latch where direction is 1, pin level otherwise; pin 2 reads 0 while clock-out is enabled.
// - data latches always accept writes; writing an input pin changes only the latch.
// - eight port D data latches, each direction set by its direction bit.
// - port D pins 0 to 6 are adc channels 8 to 14 when selected.
// - selected adc pin reads 0 if direction is 0, else the latch.
// - timer-taken port D pins ignore direction for the buffer; direction picks latch or 0.
// - pin 6 is timer A and pin 4 timer B external clock when selected.
// - while a pin is a timer clock input its direction bit only picks what a data read returns.
// - port D direction 1 is output, 0 input; reset clears all eight.
// - port D data read gives latch where direction is 1, pin level otherwise, 0 on adc- or timer-taken input pins.
`include "gpio_cd_params.svh"

module gpio_ports_cd (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  pcIn,
    output logic      [5:0]  pcOut,
    output logic      [5:0]  pcOe,
    input  wire logic [7:0]  pdIn,
    output logic      [7:0]  pdOut,
    output logic      [7:0]  pdOe,
    input  wire logic [4:0]  adcChannelSelect,
    input  wire logic [2:0]  timerAPrescaleSelect,
    input  wire logic [2:0]  timerBPrescaleSelect,
    output logic             timerAExternalClock,
    output logic             timerBExternalClock
);

    gpio_cd_pkg::gpio_state_s state;
    gpio_cd_pkg::gpio_state_s next_state;

    logic [5:0] regIndex;
    logic       addrAligned;
    logic       accessPhase;
    logic       commit;
    logic [6:0] adcTaken;
    logic [7:0] pdAdcMask;
    logic [7:0] pdTimerMask;
    logic [7:0] pdTaken;
    logic       timerASel;
    logic       timerBSel;
    logic [7:0] pcReadBits;
    logic [7:0] pdReadBits;

    // one bit per port D pin that the adc mux currently points at
    function automatic logic [6:0] adc_pin_map(input logic [4:0] chan);
        logic [6:0] hit;
        hit = 7'h00;
        for (int i = 0; i < `GPIO_PD_ADC_PINS; i++) begin
            if (chan == 5'(`GPIO_ADC_PD_FIRST + i)) begin
                hit[i] = 1'b1;
            end
        end
        return hit;
    endfunction

    // output pins read the latch; inputs read the pin, or 0 when a peripheral owns it
    function automatic logic [7:0] port_read(input logic [7:0] latch,
                                             input logic [7:0] dir,
                                             input logic [7:0] pin,
                                             input logic [7:0] taken);
        return (dir & latch) | (~dir & ~taken & pin);
    endfunction

    assign regIndex    = paddr[7:2];
    assign addrAligned = (paddr[1:0] == 2'h0);
    assign accessPhase = psel && penable;
    assign commit      = accessPhase && (state.phase == gpio_cd_pkg::PHASE_READY);

    assign adcTaken    = adc_pin_map(adcChannelSelect);
    assign timerASel   = (timerAPrescaleSelect == `GPIO_PS_EXT_CLK);
    assign timerBSel   = (timerBPrescaleSelect == `GPIO_PS_EXT_CLK);
    assign pdAdcMask   = {1'b0, adcTaken};
    assign pdTimerMask = (8'(timerASel) << `GPIO_PD_TIMER_UNIT_A_PIN)
                       | (8'(timerBSel) << `GPIO_PD_TIMER_UNIT_B_PIN);
    assign pdTaken     = pdAdcMask | pdTimerMask;

    // clock-out pin 2 reads 0 regardless of direction
    always_comb begin
        pcReadBits = port_read(state.pcLatch, {2'h0, state.pcDir},
                               {2'h0, state.pcPin}, 8'h00);
        if (state.clkOutEn) begin
            pcReadBits[`GPIO_PC_CLK_PIN] = 1'b0;
        end
        pcReadBits[7:6] = 2'h0;
    end

    assign pdReadBits = port_read(state.pdLatch, state.pdDir,
                                  state.pdPin, pdTaken);

    always_comb begin
        next_state = state;

        // three-stage synchroniser; a change counts once stages two and three agree
        next_state.pcSync1 = pcIn;
        next_state.pcSync2 = state.pcSync1;
        next_state.pcSync3 = state.pcSync2;
        next_state.pdSync1 = pdIn;
        next_state.pdSync2 = state.pdSync1;
        next_state.pdSync3 = state.pdSync2;
        for (int i = 0; i < `GPIO_PC_WIDTH; i++) begin
            if (state.pcSync2[i] == state.pcSync3[i]) begin
                next_state.pcPin[i] = state.pcSync2[i];
            end
        end
        for (int i = 0; i < `GPIO_PD_WIDTH; i++) begin
            if (state.pdSync2[i] == state.pdSync3[i]) begin
                next_state.pdPin[i] = state.pdSync2[i];
            end
        end

        // one wait state lets read data come from a flop
        case (state.phase)
            gpio_cd_pkg::PHASE_WAIT: begin
                if (accessPhase) begin
                    next_state.phase   = gpio_cd_pkg::PHASE_READY;
                    next_state.pslverr = 1'b0;
                    next_state.prdata  = 32'h0000_0000;
                    if (!addrAligned) begin
                        next_state.pslverr = 1'b1;
                    end else begin
                        case (regIndex)
                            `GPIO_PC_DATA_IDX: next_state.prdata = {24'h0, pcReadBits};
                            `GPIO_PD_DATA_IDX: next_state.prdata = {24'h0, pdReadBits};
                            `GPIO_PC_DIR_IDX:  next_state.prdata =
                                {24'h0, state.clkOutEn, 1'b0, state.pcDir};
                            `GPIO_PD_DIR_IDX:  next_state.prdata = {24'h0, state.pdDir};
                            default:           next_state.pslverr = 1'b1;
                        endcase
                    end
                end
            end
            gpio_cd_pkg::PHASE_READY: begin
                next_state.phase = gpio_cd_pkg::PHASE_WAIT;
                if (commit && pwrite && addrAligned) begin
                    case (regIndex)
                        // latches take writes whatever the direction
                        `GPIO_PC_DATA_IDX: next_state.pcLatch = {2'h0, pwdata[5:0]};
                        `GPIO_PD_DATA_IDX: next_state.pdLatch = pwdata[7:0];
                        `GPIO_PC_DIR_IDX: begin
                            next_state.pcDir    = pwdata[5:0];
                            next_state.clkOutEn = pwdata[`GPIO_PC_CLKEN_BIT];
                        end
                        `GPIO_PD_DIR_IDX:  next_state.pdDir = pwdata[7:0];
                        default: ;
                    endcase
                end
            end
            default: next_state.phase = gpio_cd_pkg::PHASE_WAIT;
        endcase

        // data latches are left alone by reset
        // port C fields are six bits wide, narrower than the reset constants
        if (rst) begin
            next_state.pcDir    = 6'(`GPIO_DIR_RESET);
            next_state.pdDir    = `GPIO_DIR_RESET;
            next_state.clkOutEn = `GPIO_CLKEN_RESET;
            next_state.phase    = gpio_cd_pkg::PHASE_WAIT;
            next_state.prdata   = 32'h0000_0000;
            next_state.pslverr  = 1'b0;
            next_state.pcSync1  = 6'(`GPIO_PIN_RESET);
            next_state.pcSync2  = 6'(`GPIO_PIN_RESET);
            next_state.pcSync3  = 6'(`GPIO_PIN_RESET);
            next_state.pcPin    = 6'(`GPIO_PIN_RESET);
            next_state.pdSync1  = `GPIO_PIN_RESET;
            next_state.pdSync2  = `GPIO_PIN_RESET;
            next_state.pdSync3  = `GPIO_PIN_RESET;
            next_state.pdPin    = `GPIO_PIN_RESET;
        end

        // pin drivers follow the settled register values
        next_state.pcOutQ = next_state.pcLatch[5:0];
        next_state.pcOe   = next_state.pcDir;
        if (next_state.clkOutEn) begin
            next_state.pcOe[`GPIO_PC_CLK_PIN] = 1'b1;
        end
        next_state.pdOut = next_state.pdLatch;
        next_state.pdOe  = next_state.pdDir & ~pdTaken;
        next_state.timerAClk = timerASel && next_state.pdPin[`GPIO_PD_TIMER_UNIT_A_PIN];
        next_state.timerBClk = timerBSel && next_state.pdPin[`GPIO_PD_TIMER_UNIT_B_PIN];
    end

    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    // the clock itself cannot come from a flop; pin 2 muxes it in when enabled
    always_comb begin
        pcOut = state.pcOutQ;
        if (state.clkOutEn) begin
            pcOut[`GPIO_PC_CLK_PIN] = sys_clk;
        end
    end

    assign pcOe                = state.pcOe;
    assign pdOut               = state.pdOut;
    assign pdOe                = state.pdOe;
    assign prdata              = state.prdata;
    assign pready              = (state.phase == gpio_cd_pkg::PHASE_READY);
    assign pslverr             = state.pslverr;
    assign timerAExternalClock = state.timerAClk;
    assign timerBExternalClock = state.timerBClk;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic pcDataRead;
    logic pdDataRead;
    logic pdDataWrite;
    assign pcDataRead  = commit && !pwrite && regIndex == `GPIO_PC_DATA_IDX && addrAligned;
    assign pdDataRead  = commit && !pwrite && regIndex == `GPIO_PD_DATA_IDX && addrAligned;
    assign pdDataWrite = commit && pwrite && regIndex == `GPIO_PD_DATA_IDX && addrAligned;

    pc_dir_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0)
        rst |=> (pcOe == 6'h00) && !state.clkOutEn)
        else $error("port C drivers not off after reset");
    pd_dir_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0)
        rst |=> (pdOe == 8'h00) && (state.pdDir == 8'h00))
        else $error("port D drivers not off after reset");
    clk_out_drive_a: assert property (
        state.clkOutEn && $past(state.clkOutEn) |-> pcOe[2])
        else $error("clock output enabled but pin 2 not driven");
    pd_write_latch_a: assert property (
        pdDataWrite |=> state.pdLatch == $past(pwdata[7:0]))
        else $error("port D latch missed a write");
    pc_read_latch_a: assert property (
        pcDataRead && !state.clkOutEn && $past(pcDataRead == 1'b0)
        |-> ((prdata[5:0] ^ state.pcLatch[5:0]) & state.pcDir) == 6'h00)
        else $error("port C output pin did not read its latch");
    clk_pin_read_a: assert property (
        pcDataRead && state.clkOutEn && $past(state.clkOutEn) |-> !prdata[2])
        else $error("clock-out pin read back nonzero");
    adc_pin_read_a: assert property (
        pdDataRead && $stable(adcChannelSelect) && $stable(state.pdDir)
        |-> (prdata[6:0] & adcTaken & ~state.pdDir[6:0]) == 7'h00)
        else $error("adc input pin read back nonzero");
    timer_pin_float_a: assert property (
        timerASel && $past(timerASel) |-> !pdOe[6])
        else $error("timer A clock pin driven");
    pd_read_out_a: assert property (
        pdDataRead && $stable(state.pdDir)
        |-> ((prdata[7:0] ^ state.pdLatch) & state.pdDir) == 8'h00)
        else $error("port D output pin did not read its latch");
    bus_wait_a: assert property (
        accessPhase && !pready |=> pready ##1 !pready)
        else $error("bus answer not after one wait state");

    // write strobes per register, for the write-landing checks
    logic pcDataWrite;
    logic pcDirWrite;
    logic pdDirWrite;
    assign pcDataWrite = commit && pwrite && regIndex == `GPIO_PC_DATA_IDX && addrAligned;
    assign pcDirWrite  = commit && pwrite && regIndex == `GPIO_PC_DIR_IDX && addrAligned;
    assign pdDirWrite  = commit && pwrite && regIndex == `GPIO_PD_DIR_IDX && addrAligned;

    // register writes land one edge after the completing access
    pc_write_latch_a: assert property (
        pcDataWrite |=> state.pcLatch[5:0] == $past(pwdata[5:0]))
        else $error("port C latch missed a write");

    pc_dir_write_a: assert property (
        pcDirWrite |=> state.pcDir == $past(pwdata[5:0])
        && state.clkOutEn == $past(pwdata[`GPIO_PC_CLKEN_BIT]))
        else $error("port C direction missed a write");

    pd_dir_write_a: assert property (
        pdDirWrite |=> state.pdDir == $past(pwdata[7:0]))
        else $error("port D direction missed a write");

    pc_oe_dir_a: assert property (
        !state.clkOutEn |-> pcOe == state.pcDir)
        else $error("port C drivers differ from direction");

    // read data was captured at the wait-state edge, so only stable inputs are compared
    pc_read_pin_a: assert property (
        pcDataRead && !state.clkOutEn && $stable(state.clkOutEn)
        && $stable(state.pcPin) && $stable(state.pcDir)
        |-> ((prdata[5:0] ^ state.pcPin) & ~state.pcDir) == 6'h00)
        else $error("port C input pin did not read its level");

    pd_read_pin_a: assert property (
        pdDataRead && $stable(state.pdPin) && $stable(state.pdDir)
        && $stable(pdTaken)
        |-> ((prdata[7:0] ^ state.pdPin) & ~state.pdDir & ~pdTaken) == 8'h00)
        else $error("port D input pin did not read its level");

    // peripheral-owned pins see no driver once their select has held for an edge
    pd_taken_float_a: assert property (
        $stable(pdTaken) |-> (pdOe & pdTaken) == 8'h00)
        else $error("peripheral-owned port D pin driven");

    timer_b_float_a: assert property (
        timerBSel && $past(timerBSel) |-> !pdOe[`GPIO_PD_TIMER_UNIT_B_PIN])
        else $error("timer B clock pin driven");

    // timer clocks come from the settled pin, one edge behind the select
    timer_a_gate_a: assert property (
        !$past(timerASel) |-> !timerAExternalClock)
        else $error("timer A clock active while not selected");

    timer_b_gate_a: assert property (
        !$past(timerBSel) |-> !timerBExternalClock)
        else $error("timer B clock active while not selected");

    // one answer per transfer, upper data lanes always zero
    ans_pulse_a: assert property (
        pready |=> !pready)
        else $error("bus answer longer than one cycle");

    rd_zero_a: assert property (
        pready |-> prdata[31:8] == 24'h000000
        && (!pslverr || prdata[7:0] == 8'h00))
        else $error("read data upper bits or error data nonzero");

    clk_out_cov: cover property (commit && pwrite && regIndex == `GPIO_PC_DIR_IDX
                                 && pwdata[7] ##2 pcOe[2]);
    adc_read_cov: cover property (pdDataRead && adcTaken != 7'h00);
    timer_clk_cov: cover property (timerASel ##1 timerAExternalClock);
    unmapped_cov: cover property (pready && pslverr);
    pc_read_cov: cover property (pcDataRead && state.pcDir != 6'h00);

endmodule
